/* logic/motor_cfg_consts.svh */
// Offsets, field positions, reset values and timing figures of the config bank
`ifndef MOTOR_CFG_CONSTS_SVH
`define MOTOR_CFG_CONSTS_SVH
`define CLK_MHZ 100
`define OFF_CFG_FIRST 8'ha4
`define OFF_CFG_SECOND 8'ha8
`define OFF_STATUS 8'hac
`define CFG_FIRST_RST 32'h0
`define CFG_SECOND_RST 32'h0
`define F1_PIN38_MSB 29
`define F1_PIN38_LSB 28
`define F1_DUAL_BIT 27
`define F1_ADDR_MSB 26
`define F1_ADDR_LSB 20
`define F1_VOLT_MSB 1
`define F1_VOLT_LSB 0
`define F2_FMAX_MSB 30
`define F2_FMAX_LSB 16
`define F2_SLEEP_MSB 15
`define F2_SLEEP_LSB 14
`define F2_CUR_GAIN_BIT 13
`define F2_VOLT_GAIN_BIT 12
`define F2_MODE_BIT 11
`define F2_CLK_MSB 10
`define F2_CLK_LSB 9
`define F2_EXT_EN_BIT 8
`define F2_RATE_MSB 7
`define F2_RATE_LSB 5
`define VOLT_CODE_15 2'h0
`define VOLT_CODE_30 2'h1
`define VOLT_CODE_60 2'h2
`define VOLTS_15 7'h0f
`define VOLTS_30 7'h1e
`define VOLTS_60 7'h3c
`define EXT_BASE_KHZ 11'h008
`define SLEEP_T0_US 50
`define SLEEP_T1_US 200
`define SLEEP_T2_MS 20
`define SLEEP_T3_MS 200
`define GAIN_PERIOD_MS 1
`define US_PER_MS 1000
`define SAMPLE_W 12
`define DUTY_FRAC_BITS 15
`define DUTY_FULL 16'h8000
`endif

/* logic/motor_cfg_pkg.sv */
// Types shared by the motor driver config bank
`default_nettype none
`include "motor_cfg_consts.svh"
package motor_cfg_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;
  typedef struct packed {
    logic [`SAMPLE_W-1:0] analog_output_one;
    logic [`SAMPLE_W-1:0] analog_output_two;
    logic [`SAMPLE_W-1:0] phase_a_sense_out;
    logic [`SAMPLE_W-1:0] phase_b_sense_out;
    logic [`SAMPLE_W-1:0] phase_c_sense_out;
  } analog_src_type;
  typedef struct packed {
    logic [`SAMPLE_W-1:0] routed_pin;
    logic [`SAMPLE_W-1:0] dual_pin_first;
    logic [`SAMPLE_W-1:0] dual_pin_second;
  } analog_pins_type;
  typedef enum logic [1:0] {ROUTE_DAC_TWO, ROUTE_SENSE_A, ROUTE_SENSE_B, ROUTE_SENSE_C} route_type;
  typedef enum logic [1:0] {CLK_INTERNAL, CLK_CRUDE, CLK_RESERVED, CLK_EXTERNAL} clk_src_type;
  typedef enum logic {DIV_IDLE, DIV_RUN} div_state_type;
endpackage
`default_nettype wire

/* logic/motor_driver_device_config.sv */
// Device configuration registers and the logic they steer
`timescale 1ns/1ps
`default_nettype none
`include "motor_cfg_consts.svh"
module motor_driver_device_config
#(
  parameter int unsigned SLEEP_CYC_0 = `SLEEP_T0_US * `CLK_MHZ,
  parameter int unsigned SLEEP_CYC_1 = `SLEEP_T1_US * `CLK_MHZ,
  parameter int unsigned SLEEP_CYC_2 = `SLEEP_T2_MS * `US_PER_MS * `CLK_MHZ,
  parameter int unsigned SLEEP_CYC_3 = `SLEEP_T3_MS * `US_PER_MS * `CLK_MHZ,
  parameter int unsigned GAIN_TICK_CYC = `GAIN_PERIOD_MS * `US_PER_MS * `CLK_MHZ,
  parameter logic [6:0] TARGET_ADDR_RST = 7'h00
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire motor_cfg_pkg::bus_req_type bus_req,
  output logic [31:0] rd_data,
  // Analog pin routing
  input wire motor_cfg_pkg::analog_src_type analog_src,
  output motor_cfg_pkg::analog_pins_type analog_pins,
  // Serial address and bus voltage scale
  output logic [6:0] target_addr,
  output logic [6:0] max_bus_voltage_scale,
  output logic max_bus_voltage_scale_defined,
  // Frequency speed input
  input wire logic [15:0] speed_freq,
  input wire logic speed_freq_valid,
  output logic [15:0] duty_cmd,
  output logic duty_valid,
  // Low power entry
  input wire logic speed_below,
  output logic standby_enter,
  output logic sleep_enter,
  // Dynamic gain strobes
  output logic current_gain_update,
  output logic voltage_gain_update,
  // Clock selection
  output motor_cfg_pkg::clk_src_type clk_source,
  output logic external_clock_enable,
  output logic [10:0] external_clock_rate_khz
);
  import motor_cfg_pkg::*;

  logic [31:0] cfg_first_reg;
  logic [31:0] cfg_second_reg;
  div_state_type div_state_reg;
  logic [15:0] div_rem_reg;
  logic [15:0] div_quot_reg;
  logic [14:0] div_den_reg;
  logic [3:0] div_cnt_reg;
  logic [24:0] sleep_cnt_reg;
  logic sleep_fired_reg;
  logic [24:0] sleep_limit;
  logic [16:0] gain_cnt_reg;
  logic gain_tick;
  logic [1:0] volt_code;
  logic [14:0] fmax;
  logic [15:0] rem_shift;

  // Register writes; reserved bits are read/write storage like the rest
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfg_first_reg <= `CFG_FIRST_RST | (32'(TARGET_ADDR_RST) << `F1_ADDR_LSB);
      cfg_second_reg <= `CFG_SECOND_RST;
    end
    else if (bus_req.wr)
    begin
      if (bus_req.addr == `OFF_CFG_FIRST)
        cfg_first_reg <= bus_req.wdata;
      if (bus_req.addr == `OFF_CFG_SECOND)
        cfg_second_reg <= bus_req.wdata;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rd_data <= 32'h0;
    else if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        `OFF_CFG_FIRST: rd_data <= cfg_first_reg;
        `OFF_CFG_SECOND: rd_data <= cfg_second_reg;
        `OFF_STATUS: rd_data <= {14'h0, sleep_fired_reg, div_state_reg == DIV_RUN, duty_cmd};
        default: rd_data <= 32'h0; // Unmapped reads answer zero
      endcase
    end
    else
      rd_data <= 32'h0;
  end

  // Single configurable analog pin
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      analog_pins.routed_pin <= '0;
    else
    begin
      unique case (route_type'(cfg_first_reg[`F1_PIN38_MSB:`F1_PIN38_LSB]))
        ROUTE_DAC_TWO: analog_pins.routed_pin <= analog_src.analog_output_two;
        ROUTE_SENSE_A: analog_pins.routed_pin <= analog_src.phase_a_sense_out;
        ROUTE_SENSE_B: analog_pins.routed_pin <= analog_src.phase_b_sense_out;
        ROUTE_SENSE_C: analog_pins.routed_pin <= analog_src.phase_c_sense_out;
      endcase
    end
  end

  // Dual DAC pins; a cleared dual bit parks both pins at zero
  always_ff @(posedge clk)
  begin
    if (sys_rst || !cfg_first_reg[`F1_DUAL_BIT])
    begin
      analog_pins.dual_pin_first <= '0;
      analog_pins.dual_pin_second <= '0;
    end
    else
    begin
      analog_pins.dual_pin_first <= analog_src.analog_output_one;
      analog_pins.dual_pin_second <= analog_src.analog_output_two;
    end
  end

  // Address and voltage scale decode
  assign volt_code = cfg_first_reg[`F1_VOLT_MSB:`F1_VOLT_LSB];
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      target_addr <= TARGET_ADDR_RST;
      max_bus_voltage_scale <= `VOLTS_15;
      max_bus_voltage_scale_defined <= 1'b1;
    end
    else
    begin
      target_addr <= cfg_first_reg[`F1_ADDR_MSB:`F1_ADDR_LSB];
      max_bus_voltage_scale_defined <= 1'b1;
      unique case (volt_code)
        `VOLT_CODE_15: max_bus_voltage_scale <= `VOLTS_15;
        `VOLT_CODE_30: max_bus_voltage_scale <= `VOLTS_30;
        `VOLT_CODE_60: max_bus_voltage_scale <= `VOLTS_60;
        default:
        begin
          max_bus_voltage_scale <= 7'h00; // Undefined code gives no scale
          max_bus_voltage_scale_defined <= 1'b0;
        end
      endcase
    end
  end

  // Duty divider: restoring long division, one quotient bit per cycle
  assign fmax = cfg_second_reg[`F2_FMAX_MSB:`F2_FMAX_LSB];
  assign rem_shift = {div_rem_reg[14:0], 1'b0};
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      div_state_reg <= DIV_IDLE;
      div_rem_reg <= 16'h0;
      div_quot_reg <= 16'h0;
      div_den_reg <= 15'h0;
      div_cnt_reg <= 4'h0;
      duty_cmd <= 16'h0;
      duty_valid <= 1'b0;
    end
    else
    begin
      duty_valid <= 1'b0;
      unique case (div_state_reg)
        DIV_IDLE:
        begin
          if (speed_freq_valid)
          begin
            if (fmax == 15'h0)
            begin
              duty_cmd <= 16'h0; // No full scale set, no command
              duty_valid <= 1'b1;
            end
            else if (speed_freq >= {1'b0, fmax})
            begin
              duty_cmd <= `DUTY_FULL; // Clamp at 100 percent
              duty_valid <= 1'b1;
            end
            else
            begin
              div_rem_reg <= speed_freq;
              div_den_reg <= fmax; // Snapshot so a write mid-run is harmless
              div_quot_reg <= 16'h0;
              div_cnt_reg <= 4'h0;
              div_state_reg <= DIV_RUN;
            end
          end
        end
        DIV_RUN:
        begin
          if (rem_shift >= {1'b0, div_den_reg})
          begin
            div_rem_reg <= rem_shift - {1'b0, div_den_reg};
            div_quot_reg <= {div_quot_reg[14:0], 1'b1};
          end
          else
          begin
            div_rem_reg <= rem_shift;
            div_quot_reg <= {div_quot_reg[14:0], 1'b0};
          end
          div_cnt_reg <= div_cnt_reg + 4'h1;
          if (div_cnt_reg == 4'(`DUTY_FRAC_BITS - 1))
          begin
            duty_cmd <= {div_quot_reg[14:0], rem_shift >= {1'b0, div_den_reg}};
            duty_valid <= 1'b1;
            div_state_reg <= DIV_IDLE;
          end
        end
      endcase
    end
  end

  // Sleep entry timer; the time code is read live
  always_comb
  begin
    unique case (cfg_second_reg[`F2_SLEEP_MSB:`F2_SLEEP_LSB])
      2'h0: sleep_limit = 25'(SLEEP_CYC_0);
      2'h1: sleep_limit = 25'(SLEEP_CYC_1);
      2'h2: sleep_limit = 25'(SLEEP_CYC_2);
      2'h3: sleep_limit = 25'(SLEEP_CYC_3);
    endcase
  end

  // Fires once per high stretch of speed_below, then waits for speed_below to fall
  always_ff @(posedge clk)
  begin
    if (sys_rst || !speed_below)
    begin
      sleep_cnt_reg <= 25'h0;
      sleep_fired_reg <= 1'b0;
      standby_enter <= 1'b0;
      sleep_enter <= 1'b0;
    end
    else
    begin
      standby_enter <= 1'b0;
      sleep_enter <= 1'b0;
      if (!sleep_fired_reg)
      begin
        sleep_cnt_reg <= sleep_cnt_reg + 25'h1;
        if (sleep_cnt_reg + 25'h1 >= sleep_limit)
        begin
          sleep_fired_reg <= 1'b1;
          sleep_enter <= cfg_second_reg[`F2_MODE_BIT];
          standby_enter <= !cfg_second_reg[`F2_MODE_BIT];
        end
      end
    end
  end

  // Free running millisecond tick for the gain loops
  assign gain_tick = (gain_cnt_reg == 17'(GAIN_TICK_CYC - 1));
  always_ff @(posedge clk)
  begin
    if (sys_rst || gain_tick)
      gain_cnt_reg <= 17'h0;
    else
      gain_cnt_reg <= gain_cnt_reg + 17'h1;
  end

  // Gain strobes; a cleared enable holds the gain fixed
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      current_gain_update <= 1'b0;
      voltage_gain_update <= 1'b0;
    end
    else
    begin
      current_gain_update <= gain_tick && cfg_second_reg[`F2_CUR_GAIN_BIT];
      voltage_gain_update <= gain_tick && cfg_second_reg[`F2_VOLT_GAIN_BIT];
    end
  end

  // Clock source and external reference
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      clk_source <= CLK_INTERNAL;
      external_clock_enable <= 1'b0;
      external_clock_rate_khz <= `EXT_BASE_KHZ;
    end
    else
    begin
      // Reserved code falls back to internal rather than an unknown source
      if (clk_src_type'(cfg_second_reg[`F2_CLK_MSB:`F2_CLK_LSB]) == CLK_RESERVED)
        clk_source <= CLK_INTERNAL;
      else
        clk_source <= clk_src_type'(cfg_second_reg[`F2_CLK_MSB:`F2_CLK_LSB]);
      external_clock_enable <= cfg_second_reg[`F2_EXT_EN_BIT];
      external_clock_rate_khz <= `EXT_BASE_KHZ << cfg_second_reg[`F2_RATE_MSB:`F2_RATE_LSB];
    end
  end

  // Checks next to the logic
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_div_start;
    div_state_reg == DIV_IDLE && speed_freq_valid && fmax != 15'h0 && speed_freq < {1'b0, fmax};
  endsequence
  sequence s_div_done;
    ##[15:16] duty_valid && duty_cmd < `DUTY_FULL;
  endsequence

  chk_pin_route: assert property (cfg_first_reg[`F1_PIN38_MSB:`F1_PIN38_LSB] == ROUTE_SENSE_A |=>
    analog_pins.routed_pin == $past(analog_src.phase_a_sense_out))
    else $error("routed pin does not follow phase a sense");
  chk_dual_pins: assert property (cfg_first_reg[`F1_DUAL_BIT] |=>
    analog_pins.dual_pin_first == $past(analog_src.analog_output_one))
    else $error("dual pin first does not carry dac one");
  chk_addr_out: assert property (bus_req.wr && bus_req.addr == `OFF_CFG_FIRST ##2 !$past(bus_req.wr)
    |-> target_addr == $past(bus_req.wdata[`F1_ADDR_MSB:`F1_ADDR_LSB], 2))
    else $error("target address not taken from written field");
  chk_max_bus_voltage_scale: assert property (volt_code == `VOLT_CODE_60 |=>
    max_bus_voltage_scale == `VOLTS_60)
    else $error("code two does not give 60 volts");
  chk_duty_done: assert property (s_div_start |-> s_div_done)
    else $error("duty result missing or above full scale");
  chk_sleep_entry: assert property ($rose(sleep_enter) |-> $past(speed_below) &&
    $past(sleep_cnt_reg) + 25'h1 >= $past(sleep_limit) && $past(cfg_second_reg[`F2_MODE_BIT]))
    else $error("sleep entry without a full low stretch");
  chk_cur_gain: assert property (current_gain_update |->
    $past(gain_tick) && $past(cfg_second_reg[`F2_CUR_GAIN_BIT]))
    else $error("current gain strobe without tick or enable");
  chk_volt_gain: assert property (!cfg_second_reg[`F2_VOLT_GAIN_BIT] [*2] |->
    !voltage_gain_update)
    else $error("voltage gain strobe while disabled");
  chk_clk_source: assert property (clk_source != CLK_RESERVED)
    else $error("reserved clock source driven");
  chk_ext_clk: assert property (external_clock_enable |-> $past(cfg_second_reg[`F2_EXT_EN_BIT]))
    else $error("external clock mode without its enable");
  chk_ext_rate: assert property (cfg_second_reg[`F2_RATE_MSB:`F2_RATE_LSB] == 3'h7 |=>
    external_clock_rate_khz == 11'h400)
    else $error("top rate code is not 1024 khz");
endmodule
`default_nettype wire

/* tb/motor_driver_device_config_bench.sv */
// Self-checking bench for the motor driver config bank
`timescale 1ns/1ps
`default_nettype none
`include "motor_cfg_consts.svh"
module motor_driver_device_config_bench;
  import motor_cfg_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  bus_req_type bus_req = '0;
  logic [31:0] rd_data;
  analog_src_type analog_src = '0;
  analog_pins_type analog_pins;
  logic [6:0] target_addr;
  logic [6:0] max_bus_voltage_scale;
  logic max_bus_voltage_scale_defined;
  logic [15:0] speed_freq = 16'h0;
  logic speed_freq_valid = 1'b0;
  logic [15:0] duty_cmd;
  logic duty_valid;
  logic speed_below = 1'b0;
  logic standby_enter;
  logic sleep_enter;
  logic current_gain_update;
  logic voltage_gain_update;
  clk_src_type clk_source;
  logic external_clock_enable;
  logic [10:0] external_clock_rate_khz;
  int failures = 0;
  int compares = 0;
  int seed = 8;
  logic [31:0] rd_notes[$];
  logic [15:0] duty_notes[$];
  logic rd_seen = 1'b0;
  // Short counts so every sleep code and the gain tick fit in a brief run
  localparam int SLEEP_LIM [4] = '{5, 8, 12, 16};

  motor_driver_device_config #(.SLEEP_CYC_0(5), .SLEEP_CYC_1(8), .SLEEP_CYC_2(12),
    .SLEEP_CYC_3(16), .GAIN_TICK_CYC(20)) i_motor_driver_device_config (
    .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data(rd_data),
    .analog_src(analog_src), .analog_pins(analog_pins), .target_addr(target_addr),
    .max_bus_voltage_scale(max_bus_voltage_scale), .max_bus_voltage_scale_defined(max_bus_voltage_scale_defined),
    .speed_freq(speed_freq), .speed_freq_valid(speed_freq_valid), .duty_cmd(duty_cmd),
    .duty_valid(duty_valid), .speed_below(speed_below), .standby_enter(standby_enter),
    .sleep_enter(sleep_enter), .current_gain_update(current_gain_update),
    .voltage_gain_update(voltage_gain_update), .clk_source(clk_source),
    .external_clock_enable(external_clock_enable),
    .external_clock_rate_khz(external_clock_rate_khz));

  always #5 clk = ~clk;

  task automatic note_fail(input string msg);
    failures++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      note_fail(msg);
    end
  endtask

  task automatic conclude();
    if (failures == 0 && compares > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Single-cycle strobes, one idle cycle between transfers
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic bus_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd_notes.push_back(exp);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
  endtask

  task automatic bound_hit(input int n, input int lim);
    if (n >= lim)
    begin
      note_fail("wait ran out");
      conclude();
    end
  endtask

  // Results are matched against the oldest note when they appear
  always @(posedge clk)
  begin
    rd_seen <= bus_req.rd;
    if (rd_seen)
    begin
      if (rd_notes.size() == 0)
        note_fail("read without note");
      else
        check(rd_data === rd_notes.pop_front(), "read data");
    end
    if (duty_valid === 1'b1)
    begin
      if (duty_notes.size() == 0)
        note_fail("duty without note");
      else
        check(duty_cmd === duty_notes.pop_front(), "duty value");
    end
  end

  initial
  begin : main
    logic [31:0] first;
    logic [6:0] addr;
    logic [11:0] pin;
    logic [14:0] fmax;
    logic [15:0] f;
    logic [15:0] d;
    int n;
    int cur;
    int volt;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    bus_read(`OFF_CFG_SECOND, 32'h0);
    bus_read(`OFF_CFG_FIRST, 32'h0);
    bus_read(8'h10, 32'h0);
    check(external_clock_enable === 1'b0 && clk_source === CLK_INTERNAL, "reset clk");
    // Every routing, voltage, clock and rate code
    for (int i = 0; i < 8; i++)
    begin
      addr = 7'($random(seed));
      analog_src <= 60'({$random(seed), $random(seed)});
      first = {2'h0, i[1:0], i[0], addr, 18'h0, i[1:0]};
      bus_write(`OFF_CFG_FIRST, first);
      bus_write(`OFF_CFG_SECOND, {21'h0, i[1:0], i[0], i[2:0], 5'h0});
      bus_read(`OFF_CFG_FIRST, first);
      bus_read(`OFF_CFG_SECOND, {21'h0, i[1:0], i[0], i[2:0], 5'h0});
      pin = (i[1:0] == 2'h0) ? analog_src.analog_output_two :
        (i[1:0] == 2'h1) ? analog_src.phase_a_sense_out :
        (i[1:0] == 2'h2) ? analog_src.phase_b_sense_out : analog_src.phase_c_sense_out;
      check(analog_pins.routed_pin === pin, "routed pin");
      check(analog_pins.dual_pin_first === (i[0] ? analog_src.analog_output_one : 12'h0) &&
        analog_pins.dual_pin_second === (i[0] ? analog_src.analog_output_two : 12'h0),
        "dual pins");
      check(target_addr === addr, "target address");
      check(max_bus_voltage_scale === ((i[1:0] == 2'h0) ? `VOLTS_15 : (i[1:0] == 2'h1) ?
        `VOLTS_30 : (i[1:0] == 2'h2) ? `VOLTS_60 : 7'h00) &&
        max_bus_voltage_scale_defined === (i[1:0] != 2'h3), "bus voltage");
      check(clk_source === ((i[1:0] == 2'h2) ? CLK_INTERNAL : clk_src_type'(i[1:0])),
        "clock source");
      check(external_clock_enable === i[0], "ext enable");
      check(external_clock_rate_khz === (11'h008 << i[2:0]), "ext rate");
    end
    // Sleep timing for all four codes, both modes
    for (int k = 0; k < 4; k++)
    begin
      bus_write(`OFF_CFG_SECOND, {16'h0, k[1:0], 2'h0, k[0], 11'h0});
      @(posedge clk);
      speed_below <= 1'b1;
      n = 0;
      while (!(sleep_enter | standby_enter) && n < 40)
      begin
        @(posedge clk);
        n++;
      end
      bound_hit(n, 40);
      check(n == SLEEP_LIM[k] + 1, "sleep delay");
      check(sleep_enter === k[0] && standby_enter === !k[0], "mode pulse");
      cur = 0;
      repeat (20)
      begin
        @(posedge clk);
        cur += int'(sleep_enter | standby_enter);
      end
      check(cur == 0, "second pulse");
      speed_below <= 1'b0;
    end
    // Gain strobes: current only, voltage only, none
    for (int g = 0; g < 3; g++)
    begin
      bus_write(`OFF_CFG_SECOND, {18'h0, g == 0, g == 1, 12'h0});
      repeat (3) @(posedge clk);
      cur = 0;
      volt = 0;
      repeat (40)
      begin
        @(posedge clk);
        cur += int'(current_gain_update === 1'b1);
        volt += int'(voltage_gain_update === 1'b1);
      end
      check(cur == ((g == 0) ? 2 : 0), "current gain");
      check(volt == ((g == 1) ? 2 : 0), "voltage gain");
    end
    // Duty: zero scale, full scale, above, random below with a dropped request
    for (int t = 0; t < 7; t++)
    begin
      fmax = (t == 0) ? 15'h0 : (15'($random(seed)) | 15'h1);
      f = {1'b0, 15'($random(seed))};
      if (t == 1)
        f = {1'b0, fmax};
      else if (t == 2)
        f = {1'b0, fmax} + 16'h1;
      else if (t > 2)
        f = f % {1'b0, fmax};
      bus_write(`OFF_CFG_SECOND, {1'b0, fmax, 16'h0});
      @(posedge clk);
      speed_freq <= f;
      speed_freq_valid <= 1'b1;
      d = (fmax == 15'h0) ? 16'h0 : (f >= {1'b0, fmax}) ? `DUTY_FULL :
        16'(({16'h0, f} << 15) / {17'h0, fmax});
      duty_notes.push_back(d);
      @(posedge clk);
      speed_freq <= f ^ 16'h1;
      speed_freq_valid <= (t > 2);
      @(posedge clk);
      speed_freq_valid <= 1'b0;
      n = 0;
      while (duty_notes.size() != 0 && n < 40)
      begin
        @(posedge clk);
        n++;
      end
      bound_hit(n, 40);
      repeat (20) @(posedge clk);
      check(duty_notes.size() == 0, "extra duty");
      // Status word: divider idle, no sleep latched, last duty result
      bus_read(`OFF_STATUS, {16'h0, d});
    end
    repeat (4) @(posedge clk);
    check(rd_notes.size() == 0, "reads left over");
    conclude();
  end
endmodule
`default_nettype wire
